// >>> bench/ssq_conv_model.sv
// partner model: converter cards, sample source and output busy
`timescale 1ns/1ps
module ssq_conv_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_dac_load,
  input wire logic i_hold_busy,
  output logic o_dac_busy,
  output logic [15:0] o_adc_sample
);
  logic [4:0] busy_reg;
  logic [4:0] busy_next;
  logic [15:0] smp_reg;
  logic [15:0] smp_next;
  // busy while converting, new sample after each transfer
  always_comb begin
    busy_next = (busy_reg != 5'h00) ? busy_reg - 5'h01 : 5'h00;
    smp_next = smp_reg;
    if (i_dac_load) begin
      busy_next = 5'h14;
      smp_next = smp_reg + 16'h1111;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_reg <= 5'h00;
      smp_reg <= 16'h0A5F;
    end else begin
      busy_reg <= busy_next;
      smp_reg <= smp_next;
    end
  end
  assign o_dac_busy = i_hold_busy | (busy_reg != 5'h00);
  assign o_adc_sample = smp_reg;
endmodule

// >>> bench/ssq_sequencer_assertions.sv
// checker: port-level assertions for the standalone sequencer
`timescale 1ns/1ps
module ssq_sequencer_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic o_standalone,
  input wire logic [ssq_pkg::CNT_W-1:0] o_count,
  input wire logic o_read_sample,
  input wire logic o_write_output_sample,
  input wire logic [ssq_pkg::DATA_W-1:0] o_bus_rdata,
  input wire logic o_bus_rdata_oe,
  input wire logic o_buffer_full_flag,
  input wire logic o_dac_load,
  input wire logic [ssq_pkg::SEL_W-1:0] o_dac_select
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // -------------------------------------------------
  // assertions
  // -------------------------------------------------
  AST_OE_READ: assert property (
    o_bus_rdata_oe == o_read_sample)
    else $error("bus enable differs from read command");
  AST_SA_OE_WIN: assert property (
    o_standalone && $past(o_standalone, 2) && o_bus_rdata_oe
    |-> $past(o_count) == 9'h01F)
    else $error("standalone bus drive outside read state");
  AST_RDATA_IDLE: assert property (
    !o_bus_rdata_oe |-> o_bus_rdata == 16'h0000)
    else $error("bus data not zero while released");
  AST_SA_READ: assert property (
    o_standalone && $past(o_standalone, 2) && $rose(o_read_sample)
    |-> o_count == 9'h01F)
    else $error("standalone read away from state 31");
  AST_SA_WRITE: assert property (
    o_standalone && $past(o_standalone, 2) && $rose(o_buffer_full_flag)
    |-> $past(o_count) == 9'h03F)
    else $error("standalone write away from state 63");
  AST_SA_WRAP: assert property (
    o_standalone && $past(o_standalone, 2) && $changed(o_count)
    |-> o_count == (($past(o_count) == 9'h063) ? 9'h000
        : $past(o_count) + 9'h001))
    else $error("standalone counter step or wrap wrong");
  AST_NORM_CNT: assert property (
    !o_standalone && $changed(o_count)
    |-> o_count == 9'h000 || o_count == $past(o_count) + 9'h001)
    else $error("normal counter step wrong");
  AST_LOAD_FULL: assert property (
    o_dac_load |-> $past(o_buffer_full_flag)
    && o_buffer_full_flag == o_write_output_sample ##1 !o_dac_load)
    else $error("transfer without full buffer or flag kept");
  AST_SA_SEL: assert property (
    o_standalone && o_dac_load |-> o_dac_select == 4'hC)
    else $error("standalone select code wrong");
endmodule

bind ssq_sequencer ssq_sequencer_chk ssq_sequencer_chk_i (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .o_standalone(o_standalone),
  .o_count(o_count),
  .o_read_sample(o_read_sample),
  .o_write_output_sample(o_write_output_sample),
  .o_bus_rdata(o_bus_rdata),
  .o_bus_rdata_oe(o_bus_rdata_oe),
  .o_buffer_full_flag(o_buffer_full_flag),
  .o_dac_load(o_dac_load),
  .o_dac_select(o_dac_select)
);

// >>> bench/test_ssq_sequencer.sv
// testbench: standalone and normal operation of the sequencer
`timescale 1ns/1ps
module test_ssq_sequencer;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic line = 1'b0;
  logic xen = 1'b1;
  logic pen = 1'b0;
  logic [2:0] ph = 3'h0;
  logic xph = 1'b0;
  logic pph = 1'b0;
  logic rs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [3:0] sel = 4'h0;
  logic [15:0] wd = 16'h0000;
  logic hold = 1'b0;
  logic busy, sa, rso, wro, oe, flag, load;
  logic [8:0] cnt;
  logic [3:0] dsel;
  logic [15:0] smp, rdata, ddata;
  int num_errors = 0;
  int n_tests = 0;

  ssq_sequencer ssq_sequencer_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_standalone_test_line(line), .i_crystal_phase_clock(xph),
    .i_processor_timing_phase(pph), .i_restart_n(rs_n), .i_read_n(rd_n),
    .i_write_output_sample_n(wr_n), .i_select(sel), .i_bus_wdata(wd),
    .i_adc_sample(smp), .i_dac_busy(busy), .o_standalone(sa),
    .o_count(cnt), .o_read_sample(rso), .o_write_output_sample(wro),
    .o_bus_rdata(rdata), .o_bus_rdata_oe(oe), .o_buffer_full_flag(flag),
    .o_dac_load(load), .o_dac_data(ddata), .o_dac_select(dsel));
  ssq_conv_model ssq_conv_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_dac_load(load), .i_hold_busy(hold), .o_dac_busy(busy),
    .o_adc_sample(smp));

  always #2 i_clk = ~i_clk;
  // phase sources, one card tick every 8 clk
  always @(posedge i_clk) begin
    ph <= ph + 3'h1;
    xph <= xen & ph[2];
    pph <= pen & ph[2];
  end

  // -------------------------------------------------
  // shared tasks
  // -------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  // wait for 0 bus enable, 1 full flag, 2 transfer
  task automatic wait_on(input int w);
    for (int k = 0; k < 2000; k++) begin
      @(negedge i_clk);
      if ((w == 0 && oe === 1'b1) || (w == 1 && flag === 1'b1)
          || (w == 2 && load === 1'b1)) return;
    end
    $display("wrong value wait %0d expected 1 seen 0", w);
    num_errors++;
    end_of_test();
  endtask
  task automatic do_reset(input logic mode);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    line <= mode;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
  endtask

  // -------------------------------------------------
  // scenarios
  // -------------------------------------------------
  // loopback with external read and write asserted but ignored
  task automatic t_standalone();
    logic [15:0] s;
    do_reset(1'b1);
    rd_n <= 1'b0;
    wr_n <= 1'b0;
    repeat (2) begin
      wait_on(0);
      s = smp;
      chk("loop sample", s, rdata);
      chk("read state", 16'h001F, {7'h00, cnt});
      chk("read command", 16'h0001, {15'h0000, rso});
      chk("standalone status", 16'h0001, {15'h0000, sa});
      wait_on(2);
      chk("loop data", s, ddata);
      chk("loop select", 16'h000C, {12'h000, dsel});
    end
  endtask
  // external restart, phase, read, and transfer held off while busy
  task automatic t_normal();
    logic [8:0] c;
    logic bad;
    bad = 1'b0;
    do_reset(1'b0);
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    pen <= 1'b1;
    rs_n <= 1'b0;
    repeat (40) @(negedge i_clk);
    chk("restart count", 16'h0000, {7'h00, cnt});
    chk("normal status", 16'h0000, {15'h0000, sa});
    @(posedge i_clk);
    rs_n <= 1'b1;
    repeat (80) @(posedge i_clk);
    pen <= 1'b0;
    repeat (8) @(negedge i_clk);
    c = cnt;
    repeat (60) @(negedge i_clk);
    chk("held count", {7'h00, c}, {7'h00, cnt});
    @(posedge i_clk);
    pen <= 1'b1;
    repeat (400) begin
      @(negedge i_clk);
      if (oe !== 1'b0) bad = 1'b1;
    end
    chk("idle enable", 16'h0000, {15'h0000, bad});
    @(posedge i_clk);
    rd_n <= 1'b0;
    wait_on(0);
    chk("bus data", smp, rdata);
    @(posedge i_clk);
    rd_n <= 1'b1;
    hold <= 1'b1;
    wd <= 16'h1234;
    sel <= 4'h5;
    wr_n <= 1'b0;
    repeat (11) @(posedge i_clk);
    @(negedge i_clk);
    chk("write command", 16'h0001, {15'h0000, wro});
    @(posedge i_clk);
    wr_n <= 1'b1;
    repeat (60) @(negedge i_clk);
    chk("flag while busy", 16'h0001, {15'h0000, flag});
    @(posedge i_clk);
    hold <= 1'b0;
    wait_on(2);
    chk("output data", 16'h1234, ddata);
    chk("output select", 16'h0005, {12'h000, dsel});
    chk("flag after transfer", 16'h0000, {15'h0000, flag});
  endtask

  initial begin
    t_standalone();
    t_normal();
    end_of_test();
  end
endmodule

// >>> hdl/ssq_pkg.sv
// package: constants and carrier types for the standalone sequencer
package ssq_pkg;

  // -------------------------------------------------
  // counter and decode constants
  // -------------------------------------------------
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] CNT_RST = 9'h000;
  localparam logic [CNT_W-1:0] CNT_WRAP = 9'(99);
  localparam logic [CNT_W-1:0] CNT_READ = 9'(31);
  localparam logic [CNT_W-1:0] CNT_WRITE = 9'(63);
  localparam int SEL_BIT = 5;
  localparam int SAMPLE_INTERVAL_MS = 50;

  // -------------------------------------------------
  // data and select layout
  // -------------------------------------------------
  localparam int DATA_W = 16;
  localparam int SEL_W = 4;
  localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
  localparam logic [SEL_W-1:0] SEL_OUT_AB = 4'h3;
  localparam logic [SEL_W-1:0] SEL_OUT_CD = 4'hC;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam int SYNC_STAGES = 2;

  // clock sources in MHz, for reference only
  localparam real CRYSTAL_MHZ = 2.048;
  localparam real SYS_CLK_MHZ = 250.0;

  // -------------------------------------------------
  // carrier types
  // -------------------------------------------------
  // conversion control group, active high inside the block
  typedef struct packed {
    logic restart;
    logic read;
    logic write;
    logic [SEL_W-1:0] select;
  } ssq_ctl_t;

  // every pin input, captured together by the synchroniser
  typedef struct packed {
    logic standalone_test_line;
    logic crystal_phase_clock;
    logic processor_timing_phase;
    logic restart_n;
    logic read_n;
    logic write_n;
    logic [SEL_W-1:0] select;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] sample;
    logic dac_busy;
  } ssq_pins_t;

endpackage

// >>> hdl/ssq_sequencer.sv
// module: converter card sequencer with standalone test operation
// Function
// RL1 - standalone line high: use internal controls
// RL2 - standalone: cycle counter always enabled
// RL3 - input 1 to A/B, input 2 to C/D; code writes only at state 63, bit 5 set, so always C/D, never A/B
// RL4 - standalone: counter resets at count 99
// RL5 - standalone: clock from crystal phase clock
// RL6 - read at state 31, write at 63
// RL7 - output select from counter bit 5
// RL8 - normal: restart synchronously clears 9-bit counter
// RL9 - normal: clock from processor timing phase
// RL10 - drive audio bus only during read
// RL11 - write loads buffer, flag until transfer
// RL12 - standalone line low: use external controls
`timescale 1ns/1ps
module ssq_sequencer (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_standalone_test_line,
  input wire logic i_crystal_phase_clock,
  input wire logic i_processor_timing_phase,
  input wire logic i_restart_n,
  input wire logic i_read_n,
  input wire logic i_write_output_sample_n,
  input wire logic [ssq_pkg::SEL_W-1:0] i_select,
  input wire logic [ssq_pkg::DATA_W-1:0] i_bus_wdata,
  input wire logic [ssq_pkg::DATA_W-1:0] i_adc_sample,
  input wire logic i_dac_busy,
  output logic o_standalone,
  output logic [ssq_pkg::CNT_W-1:0] o_count,
  output logic o_read_sample,
  output logic o_write_output_sample,
  output logic [ssq_pkg::DATA_W-1:0] o_bus_rdata,
  output logic o_bus_rdata_oe,
  output logic o_buffer_full_flag,
  output logic o_dac_load,
  output logic [ssq_pkg::DATA_W-1:0] o_dac_data,
  output logic [ssq_pkg::SEL_W-1:0] o_dac_select
);

  // -------------------------------------------------
  // pin synchronisation
  // -------------------------------------------------
  ssq_pkg::ssq_pins_t pins_raw;
  ssq_pkg::ssq_pins_t pins;
  logic [$bits(ssq_pkg::ssq_pins_t)-1:0] pins_sync_vec;

  // gather every pin input into one vector
  always_comb begin
    pins_raw.standalone_test_line = i_standalone_test_line;
    pins_raw.crystal_phase_clock = i_crystal_phase_clock;
    pins_raw.processor_timing_phase = i_processor_timing_phase;
    pins_raw.restart_n = i_restart_n;
    pins_raw.read_n = i_read_n;
    pins_raw.write_n = i_write_output_sample_n;
    pins_raw.select = i_select;
    pins_raw.wdata = i_bus_wdata;
    pins_raw.sample = i_adc_sample;
    pins_raw.dac_busy = i_dac_busy;
  end

  ssq_sync #(
    .W($bits(ssq_pkg::ssq_pins_t))
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async(pins_raw),
    .o_sync(pins_sync_vec)
  );

  assign pins = ssq_pkg::ssq_pins_t'(pins_sync_vec);

  // -------------------------------------------------
  // card clock selection and tick
  // -------------------------------------------------
  logic phase_d_reg;
  logic phase_d_next;
  logic card_phase;
  logic card_tick;

  // RL5 crystal phase in standalone
  // RL9 processor phase otherwise
  assign card_phase = pins.standalone_test_line ?
                      pins.crystal_phase_clock :
                      pins.processor_timing_phase;

  // rising edge of the selected phase gives one-cycle tick
  always_comb begin
    phase_d_next = card_phase;
    card_tick = card_phase & ~phase_d_reg;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_d_reg <= 1'b0;
    end else begin
      phase_d_reg <= phase_d_next;
    end
  end

  // -------------------------------------------------
  // synchroniser fill after reset
  // -------------------------------------------------
  logic [ssq_pkg::SYNC_STAGES-1:0] fill_reg;
  logic [ssq_pkg::SYNC_STAGES-1:0] fill_next;
  logic pins_valid;

  // stages reset low, so active-low pins would look asserted until filled
  always_comb begin
    fill_next = {fill_reg[ssq_pkg::SYNC_STAGES-2:0], 1'b1};
    pins_valid = fill_reg[ssq_pkg::SYNC_STAGES-1];
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fill_reg <= {ssq_pkg::SYNC_STAGES{1'b0}};
    end else begin
      fill_reg <= fill_next;
    end
  end

  // -------------------------------------------------
  // control source selection
  // -------------------------------------------------
  logic [ssq_pkg::CNT_W-1:0] cnt_reg;
  logic [ssq_pkg::CNT_W-1:0] cnt_next;
  ssq_pkg::ssq_ctl_t ext_ctl;
  ssq_pkg::ssq_ctl_t int_ctl;
  ssq_pkg::ssq_ctl_t ctl;

  // external controls, processor lines are active low
  always_comb begin
    ext_ctl.restart = pins_valid & ~pins.restart_n;
    ext_ctl.read = pins_valid & ~pins.read_n;
    ext_ctl.write = pins_valid & ~pins.write_n;
    ext_ctl.select = pins.select;
  end

  // internal controls decoded from the cycle counter
  always_comb begin
    // RL4 wrap decode
    int_ctl.restart = (cnt_reg == ssq_pkg::CNT_WRAP);
    // RL6 read and write states
    int_ctl.read = (cnt_reg == ssq_pkg::CNT_READ);
    int_ctl.write = (cnt_reg == ssq_pkg::CNT_WRITE);
    // RL7 select from counter bit
    // RL3 wants input 1 to A/B, input 2 to C/D; here the one write, at state 63, always selects C/D
    int_ctl.select = cnt_reg[ssq_pkg::SEL_BIT] ?
                     ssq_pkg::SEL_OUT_CD : ssq_pkg::SEL_OUT_AB;
  end

  // RL1 internal controls in standalone
  // RL12 external controls otherwise
  assign ctl = pins.standalone_test_line ? int_ctl : ext_ctl;

  // -------------------------------------------------
  // input cycle counter
  // -------------------------------------------------
  // RL2 counts on every card tick, no hold
  always_comb begin
    cnt_next = cnt_reg;
    if (card_tick) begin
      // RL8 synchronous clear on restart
      if (ctl.restart) begin
        cnt_next = ssq_pkg::CNT_RST;
      end else begin
        cnt_next = cnt_reg + 9'h001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= ssq_pkg::CNT_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // -------------------------------------------------
  // double buffer and output transfer
  // -------------------------------------------------
  logic [ssq_pkg::DATA_W-1:0] sample_reg;
  logic [ssq_pkg::DATA_W-1:0] sample_next;
  logic [ssq_pkg::DATA_W-1:0] buf_data_reg;
  logic [ssq_pkg::DATA_W-1:0] buf_data_next;
  logic [ssq_pkg::SEL_W-1:0] buf_sel_reg;
  logic [ssq_pkg::SEL_W-1:0] buf_sel_next;
  logic full_reg;
  logic full_next;
  logic load_reg;
  logic load_next;
  logic [ssq_pkg::DATA_W-1:0] dac_data_reg;
  logic [ssq_pkg::DATA_W-1:0] dac_data_next;
  logic [ssq_pkg::SEL_W-1:0] dac_sel_reg;
  logic [ssq_pkg::SEL_W-1:0] dac_sel_next;
  logic buf_write;
  logic buf_xfer;

  always_comb begin
    sample_next = sample_reg;
    buf_data_next = buf_data_reg;
    buf_sel_next = buf_sel_reg;
    dac_data_next = dac_data_reg;
    dac_sel_next = dac_sel_reg;
    buf_write = card_tick & ctl.write;
    buf_xfer = card_tick & full_reg & ~pins.dac_busy;
    // loopback source: sample caught while read is active
    if (card_tick && ctl.read) begin
      sample_next = pins.sample;
    end
    // RL11 write loads the double buffer
    if (buf_write) begin
      buf_data_next = pins.standalone_test_line ?
                      sample_reg : pins.wdata;
      buf_sel_next = ctl.select;
    end
    // old buffer content moves on while converter is idle
    if (buf_xfer) begin
      dac_data_next = buf_data_reg;
      dac_sel_next = buf_sel_reg;
    end
    // RL11 flag holds until transfer, reload wins
    full_next = buf_write | (full_reg & ~buf_xfer);
    load_next = buf_xfer;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sample_reg <= ssq_pkg::DATA_RST;
      buf_data_reg <= ssq_pkg::DATA_RST;
      buf_sel_reg <= ssq_pkg::SEL_RST;
      full_reg <= 1'b0;
      load_reg <= 1'b0;
      dac_data_reg <= ssq_pkg::DATA_RST;
      dac_sel_reg <= ssq_pkg::SEL_RST;
    end else begin
      sample_reg <= sample_next;
      buf_data_reg <= buf_data_next;
      buf_sel_reg <= buf_sel_next;
      full_reg <= full_next;
      load_reg <= load_next;
      dac_data_reg <= dac_data_next;
      dac_sel_reg <= dac_sel_next;
    end
  end

  // -------------------------------------------------
  // audio bus drive and status outputs
  // -------------------------------------------------
  logic oe_reg;
  logic oe_next;
  logic [ssq_pkg::DATA_W-1:0] rdata_reg;
  logic [ssq_pkg::DATA_W-1:0] rdata_next;
  logic stand_reg;
  logic stand_next;
  logic wr_reg;
  logic wr_next;

  always_comb begin
    // RL10 drive only during read command
    oe_next = ctl.read;
    rdata_next = ctl.read ? pins.sample : ssq_pkg::DATA_RST;
    stand_next = pins.standalone_test_line;
    wr_next = ctl.write;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oe_reg <= 1'b0;
      rdata_reg <= ssq_pkg::DATA_RST;
      stand_reg <= 1'b0;
      wr_reg <= 1'b0;
    end else begin
      oe_reg <= oe_next;
      rdata_reg <= rdata_next;
      stand_reg <= stand_next;
      wr_reg <= wr_next;
    end
  end

  assign o_standalone = stand_reg;
  assign o_count = cnt_reg;
  assign o_read_sample = oe_reg;
  assign o_write_output_sample = wr_reg;
  assign o_bus_rdata = rdata_reg;
  assign o_bus_rdata_oe = oe_reg;
  assign o_buffer_full_flag = full_reg;
  assign o_dac_load = load_reg;
  assign o_dac_data = dac_data_reg;
  assign o_dac_select = dac_sel_reg;

endmodule

// >>> hdl/ssq_sync.sv
// module: two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
module ssq_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  // -------------------------------------------------
  // per-bit stages
  // -------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta_reg;
      logic meta_next;
      logic sync_reg;
      logic sync_next;
      // first stage feeds only the second
      always_comb begin
        meta_next = i_async[g];
        sync_next = meta_reg;
      end
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= meta_next;
          sync_reg <= sync_next;
        end
      end
      assign o_sync[g] = sync_reg;
    end
  endgenerate

endmodule
